// ==== rtl/ccpm_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef CCPM_REGS_SVH
`define CCPM_REGS_SVH
`define CCPM_ADDR_W 4
`define CCPM_DATA_W 32
`define CCPM_NUM_CPU 4
`define CCPM_NUM_BLK 8
`define CCPM_NUM_PLL 3
`define CCPM_OFS_CPU_SEL 4'h0
`define CCPM_OFS_CPU_STAT 4'h4
`define CCPM_OFS_BLK_DIS 4'h8
`define CCPM_OFS_STATUS 4'hC
`define CCPM_CPU_STRIDE 4
`define CCPM_SEL_W 3
`define CCPM_SEL_PICK_BIT 0
`define CCPM_SEL_RATIO_LSB 1
`define CCPM_RATIO_DIV1 2'h0
`define CCPM_RATIO_DIV2 2'h1
`define CCPM_CNT_MAX_DIV1 2'h0
`define CCPM_CNT_MAX_DIV2 2'h1
`define CCPM_CNT_MAX_DIV4 2'h3
`define CCPM_STAT_BUSY_BIT 3
`define CCPM_BLK_LATCH_LSB 8
`define CCPM_THERM_BIT 0
`define CCPM_GATE_LSB 8
`define CCPM_SEL_RESET 3'h0
`define CCPM_BLK_RESET 8'h00
`define CCPM_RDATA_RESET 32'h0000_0000
`define CCPM_GAP_LAST 2'h2
`endif

// ==== rtl/ccpm_pkg.sv ====
// Types shared by the clock and power manager
package ccpm_pkg;
  typedef enum logic [1:0] {
    CCPM_RUN,
    CCPM_DRAIN,
    CCPM_LOAD
  } ccpm_sw_state_t;
endpackage

// ==== rtl/ccpm_clk_switch.sv ====
// Per CPU glitch-free clock source switch with integer divider
`timescale 1ns/1ps
`include "ccpm_regs.svh"
module ccpm_clk_switch (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] pll_tick_in,
  input wire logic [2:0] sel_in,
  input wire logic start_in,
  output logic cpu_clk_en_out,
  output logic busy_out,
  output logic [2:0] active_sel_out
);
  ccpm_pkg::ccpm_sw_state_t state, next_state;
  logic [2:0] active_sel, next_active_sel;
  logic [1:0] gap, next_gap;
  logic [1:0] div_cnt, next_div_cnt;
  logic clk_en, next_clk_en;
  logic src_tick;
  logic [1:0] ratio;
  logic [1:0] cnt_max;

  // ==========================================================
  // Source pick, divider and switch sequence
  always_comb begin
    ratio = active_sel[`CCPM_SEL_RATIO_LSB +: 2];
    if (ratio == `CCPM_RATIO_DIV1) begin
      src_tick = active_sel[`CCPM_SEL_PICK_BIT] ? pll_tick_in[1] : pll_tick_in[0];
    end else begin
      src_tick = active_sel[`CCPM_SEL_PICK_BIT] ? pll_tick_in[2] : pll_tick_in[1];
    end
    if (ratio == `CCPM_RATIO_DIV1) begin
      cnt_max = `CCPM_CNT_MAX_DIV1;
    end else if (ratio == `CCPM_RATIO_DIV2) begin
      cnt_max = `CCPM_CNT_MAX_DIV2;
    end else begin
      cnt_max = `CCPM_CNT_MAX_DIV4;
    end
    next_state = state;
    next_active_sel = active_sel;
    next_gap = gap;
    next_div_cnt = div_cnt;
    next_clk_en = 1'b0;
    unique case (state)
      ccpm_pkg::CCPM_RUN: begin
        if (src_tick) begin
          next_div_cnt = (div_cnt == cnt_max) ? 2'h0 : 2'(div_cnt + 2'h1);
        end
        next_clk_en = src_tick && (div_cnt == 2'h0);
      end
      ccpm_pkg::CCPM_DRAIN: begin
        // Output held low so no runt pulse spans the switch
        if (gap == `CCPM_GAP_LAST) begin
          next_state = ccpm_pkg::CCPM_LOAD;
        end else begin
          next_gap = 2'(gap + 2'h1);
        end
      end
      ccpm_pkg::CCPM_LOAD: begin
        next_active_sel = sel_in;
        next_div_cnt = 2'h0;
        next_state = ccpm_pkg::CCPM_RUN;
      end
    endcase
    if (start_in) begin
      next_state = ccpm_pkg::CCPM_DRAIN;
      next_gap = 2'h0;
      next_clk_en = 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ccpm_pkg::CCPM_RUN;
      active_sel <= `CCPM_SEL_RESET;
      gap <= 2'h0;
      div_cnt <= 2'h0;
      clk_en <= 1'b0;
    end else begin
      state <= next_state;
      active_sel <= next_active_sel;
      gap <= next_gap;
      div_cnt <= next_div_cnt;
      clk_en <= next_clk_en;
    end
  end

  assign cpu_clk_en_out = clk_en;
  assign busy_out = (state != ccpm_pkg::CCPM_RUN);
  assign active_sel_out = active_sel;

  // ==========================================================
  // Assertions
  a_switch_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in |=> (!cpu_clk_en_out) [*4])
    else $error("clock pulse during source switch");
  a_switch_done: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in ##1 (!start_in) [*5] |-> !busy_out && (active_sel_out == $past(sel_in, 2)))
    else $error("source switch not finished in five cycles");
  a_pulse_source: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cpu_clk_en_out |-> $past(src_tick) && $past(state == ccpm_pkg::CCPM_RUN))
    else $error("cpu clock pulse without source tick");
  a_div_spacing: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cpu_clk_en_out && (ratio != `CCPM_RATIO_DIV1) && $stable(active_sel) |-> !$past(cpu_clk_en_out))
    else $error("divided clock pulses back to back");
  a_div_pll: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cpu_clk_en_out && (ratio != `CCPM_RATIO_DIV1) && $stable(active_sel)
      |-> $past(pll_tick_in[1] || pll_tick_in[2]))
    else $error("divider fed from wrong pll");
endmodule

// ==== rtl/ccpm_top.sv ====
// Clock and power manager: idle gating, cpu clock selection, block disable
//
// Notes on behaviour
// - Idle blocks get no clock enable
// - Dispatched work restores block clock next cycle
// - Each cpu picks one of two plls
// - Cpu may use divider fed by two plls
// - Source or divider change is glitch free, quick
// - Divider ratios divide by two and four
// - Disable mask bit stops that block's clock
// - Only chip reset re-enables disabled blocks
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "ccpm_regs.svh"
module ccpm_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [2:0] pll_tick_in,
  input wire logic [7:0] blk_work_in,
  input wire logic [7:0] blk_busy_in,
  input wire logic thermal_alert_in,
  output logic [7:0] blk_clk_en_out,
  output logic [3:0] cpu_clk_en_out,
  output logic [3:0] cpu_switching_out
);
  logic [2:0] cpu_sel [`CCPM_NUM_CPU];
  logic [2:0] next_cpu_sel [`CCPM_NUM_CPU];
  logic [2:0] active_sel [`CCPM_NUM_CPU];
  logic [3:0] sel_start;
  logic [7:0] block_disable_mask, next_block_disable_mask;
  logic [7:0] blk_off, next_blk_off;
  logic [7:0] gate, next_gate;
  logic [31:0] rdata, next_rdata;
  logic wr_sel;
  logic wr_dis;

  // ==========================================================
  // Address decode
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  assign wr_sel = reg_wr_in && reg_hit(reg_addr_in, `CCPM_OFS_CPU_SEL);
  assign wr_dis = reg_wr_in && reg_hit(reg_addr_in, `CCPM_OFS_BLK_DIS);

  // ==========================================================
  // Register file
  always_comb begin
    for (int i = 0; i < `CCPM_NUM_CPU; i++) begin
      next_cpu_sel[i] = cpu_sel[i];
      if (wr_sel) begin
        next_cpu_sel[i] = reg_wdata_in[i*`CCPM_CPU_STRIDE +: `CCPM_SEL_W];
      end
    end
    next_block_disable_mask = block_disable_mask;
    next_blk_off = blk_off;
    if (wr_dis) begin
      next_block_disable_mask = reg_wdata_in[7:0];
      next_blk_off = blk_off | reg_wdata_in[7:0];
    end
    next_rdata = `CCPM_RDATA_RESET;
    if (reg_rd_in) begin
      if (reg_hit(reg_addr_in, `CCPM_OFS_CPU_SEL)) begin
        for (int i = 0; i < `CCPM_NUM_CPU; i++) begin
          next_rdata[i*`CCPM_CPU_STRIDE +: `CCPM_SEL_W] = cpu_sel[i];
        end
      end else if (reg_hit(reg_addr_in, `CCPM_OFS_CPU_STAT)) begin
        for (int i = 0; i < `CCPM_NUM_CPU; i++) begin
          next_rdata[i*`CCPM_CPU_STRIDE +: `CCPM_SEL_W] = active_sel[i];
          next_rdata[i*`CCPM_CPU_STRIDE + `CCPM_STAT_BUSY_BIT] = cpu_switching_out[i];
        end
      end else if (reg_hit(reg_addr_in, `CCPM_OFS_BLK_DIS)) begin
        next_rdata[7:0] = block_disable_mask;
        next_rdata[`CCPM_BLK_LATCH_LSB +: 8] = blk_off;
      end else if (reg_hit(reg_addr_in, `CCPM_OFS_STATUS)) begin
        next_rdata[`CCPM_THERM_BIT] = thermal_alert_in;
        next_rdata[`CCPM_GATE_LSB +: 8] = gate;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `CCPM_NUM_CPU; i++) begin
        cpu_sel[i] <= `CCPM_SEL_RESET;
      end
      block_disable_mask <= `CCPM_BLK_RESET;
      blk_off <= `CCPM_BLK_RESET;
      rdata <= `CCPM_RDATA_RESET;
    end else begin
      for (int i = 0; i < `CCPM_NUM_CPU; i++) begin
        cpu_sel[i] <= next_cpu_sel[i];
      end
      block_disable_mask <= next_block_disable_mask;
      blk_off <= next_blk_off;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_out = rdata;

  // ==========================================================
  // Idle clock gating
  always_comb begin
    next_gate = (blk_work_in | blk_busy_in) & ~blk_off;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate <= 8'h00;
    end else begin
      gate <= next_gate;
    end
  end

  assign blk_clk_en_out = gate;

  // ==========================================================
  // Per cpu clock switches
  generate
    for (genvar c = 0; c < `CCPM_NUM_CPU; c++) begin : g_cpu
      // A rewrite of an unchanged field leaves the running clock alone
      assign sel_start[c] = wr_sel &&
        (reg_wdata_in[c*`CCPM_CPU_STRIDE +: `CCPM_SEL_W] != cpu_sel[c]);
      ccpm_clk_switch u_switch (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .pll_tick_in(pll_tick_in),
        .sel_in(cpu_sel[c]),
        .start_in(sel_start[c]),
        .cpu_clk_en_out(cpu_clk_en_out[c]),
        .busy_out(cpu_switching_out[c]),
        .active_sel_out(active_sel[c])
      );
    end
  endgenerate

  // ==========================================================
  // Assertions
  a_work_wakes_clock: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ((blk_work_in & ~blk_off) != 8'h00) |=> ((blk_clk_en_out & $past(blk_work_in & ~blk_off))
      == $past(blk_work_in & ~blk_off)))
    else $error("work dispatched but clock not restored");
  a_idle_gated: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    1'b1 |=> ((blk_clk_en_out & ~$past(blk_work_in | blk_busy_in)) == 8'h00))
    else $error("idle block still clocked");
  a_disabled_dark: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wr_dis |-> ##2 ((blk_clk_en_out & $past(reg_wdata_in[7:0], 2)) == 8'h00))
    else $error("disabled block still clocked");
  a_disable_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (($past(blk_off) & ~blk_off) == 8'h00))
    else $error("disabled block came back without reset");
  a_sel_starts: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    sel_start[0] ##1 (!sel_start[0]) [*4] |-> cpu_switching_out[0] &&
      $past(cpu_switching_out[0], 3) ##1 !cpu_switching_out[0])
    else $error("select write did not start switch");
  a_read_latency: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    reg_rd_in && reg_hit(reg_addr_in, `CCPM_OFS_STATUS)
      |=> reg_rdata_out[`CCPM_THERM_BIT] == $past(thermal_alert_in))
    else $error("thermal status not visible");
endmodule

// ==== tb/ccpm_far_side.sv ====
// Far side model: pll tick sources and temperature alarm
`timescale 1ns/1ps
module ccpm_far_side (
  input wire logic mclk_in,
  input wire logic hot_in,
  output logic [2:0] pll_tick_out,
  output logic thermal_alert_out
);
  // ==========================================
  // Pll0 ticks every cycle, pll1 every 2, pll2 every 4
  logic [3:0] cnt = 4'h0;
  initial pll_tick_out = 3'h0;
  initial thermal_alert_out = 1'b0;
  always @(posedge mclk_in) begin
    cnt <= cnt + 4'h1;
    pll_tick_out <= {cnt[1:0] == 2'h0, cnt[0], 1'b1};
    thermal_alert_out <= hot_in;
  end
endmodule

// ==== tb/ccpm_top_tb.sv ====
// Self-checking bench for the clock and power manager
`timescale 1ns/1ps
`include "ccpm_regs.svh"
module ccpm_top_tb;
  logic mclk, rst_n, wr, rd, hot, alert;
  logic [3:0] addr, cpu_en, sw;
  logic [31:0] wdata, rdata, rv, shadow;
  logic [2:0] tick;
  logic [7:0] work, busy, gate;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;

  ccpm_top u_dut (.mclk_in(mclk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .pll_tick_in(tick), .blk_work_in(work), .blk_busy_in(busy),
    .thermal_alert_in(alert), .blk_clk_en_out(gate), .cpu_clk_en_out(cpu_en),
    .cpu_switching_out(sw));
  ccpm_far_side u_far (.mclk_in(mclk), .hot_in(hot), .pll_tick_out(tick),
    .thermal_alert_out(alert));

  // ==========================================
  // Clock, timeout and reporting
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  // ==========================================
  // Register bus
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask

  // ==========================================
  // Scenarios
  task automatic test_reset_values();
    for (int i = 0; i < 16; i += 4) begin
      reg_read(i[3:0], rv);
      check("reset register", rv, 32'h0000_0000);
    end
    reg_read(4'h2, rv);
    check("unmapped read", rv, 32'h0000_0000);
    $display("test reset values done");
  endtask

  task automatic test_gating();
    @(posedge mclk);
    work <= 8'h08;
    @(posedge mclk);
    work <= 8'h00;
    busy <= 8'h20;
    @(negedge mclk);
    check("gate after work", {24'h0, gate}, 32'h0000_0008);
    repeat (3) @(posedge mclk);
    busy <= 8'h00;
    @(negedge mclk);
    check("gate while busy", {24'h0, gate}, 32'h0000_0020);
    @(negedge mclk);
    check("gate when idle", {24'h0, gate}, 32'h0000_0000);
    $display("test gating done");
  endtask

  task automatic test_cpu_switch();
    logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
    int cpu, src, div, n, pulses;
    for (int k = 0; k < 6; k++) begin
      cpu = k % 4;
      src = (codes[k][2:1] == 2'h0) ? codes[k][0] : codes[k][0] + 1;
      div = (codes[k][2:1] == 2'h0) ? 1 : (codes[k][2:1] == 2'h1) ? 2 : 4;
      shadow[4*cpu +: 3] = codes[k];
      reg_write(`CCPM_OFS_CPU_SEL, shadow);
      repeat (2) @(negedge mclk);
      n = 0;
      check("switch started", {31'h0, sw[cpu]}, 32'h1);
      while (sw[cpu] !== 1'b0 && n < 20) begin
        check("pulse during switch", {31'h0, cpu_en[cpu]}, 32'h0);
        @(negedge mclk);
        n++;
      end
      check("switch bounded", {31'h0, n <= 6}, 32'h1);
      repeat (4) @(negedge mclk);
      pulses = 0;
      repeat (48) begin
        @(negedge mclk);
        pulses += cpu_en[cpu];
      end
      check("cpu pulse count", pulses, 48 / ((1 << src) * div));
      reg_read(`CCPM_OFS_CPU_STAT, rv);
      check("cpu status", (rv >> (4 * cpu)) & 32'hF, {29'h0, codes[k]});
    end
    reg_read(`CCPM_OFS_CPU_SEL, rv);
    check("select readback", rv, shadow);
    reg_write(`CCPM_OFS_CPU_SEL, shadow);
    @(negedge mclk);
    check("rewrite no switch", {28'h0, sw}, 32'h0000_0000);
    $display("test cpu switch done");
  endtask

  task automatic test_disable();
    @(posedge mclk);
    hot <= 1'b1;
    reg_write(`CCPM_OFS_BLK_DIS, 32'h0000_0004);
    reg_write(`CCPM_OFS_BLK_DIS, 32'h0000_0000);
    @(posedge mclk);
    work <= 8'h0C;
    @(posedge mclk);
    @(negedge mclk);
    check("gate of disabled block", {24'h0, gate}, 32'h0000_0008);
    reg_read(`CCPM_OFS_BLK_DIS, rv);
    check("sticky disable", rv, 32'h0000_0400);
    reg_read(`CCPM_OFS_STATUS, rv);
    check("status word", rv, 32'h0000_0801);
    $display("test disable done");
  endtask

  task automatic test_chip_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    check("gate after chip reset", {24'h0, gate}, 32'h0000_000C);
    reg_read(`CCPM_OFS_BLK_DIS, rv);
    check("disable after chip reset", rv, 32'h0000_0000);
    $display("test chip reset done");
  endtask

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    hot = 1'b0;
    addr = 4'h0;
    wdata = 32'h0000_0000;
    shadow = 32'h0000_0000;
    work = 8'h00;
    busy = 8'h00;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    test_reset_values();
    test_gating();
    test_cpu_switch();
    test_disable();
    test_chip_reset();
    final_report();
  end
endmodule
